//--- tb.sv
// Purpose: self-checking bench of the triple up/down counter
// Assumes: tuc_enc_model drives count and reset pins
// Notes: registers reached through axi4-lite tasks
`timescale 1ns/10ps
`default_nettype none
`include "tuc_map.svh"
module tb;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0] pa, pb, prst, fo, foe, led;
  int n_mismatch, num_checks, cyc;

  tuc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .phase_input_a(pa), .phase_input_b(pb),
    .channel_reset_input(prst), .flag_output_o(fo), .flag_output_oe(foe), .front_led(led));
  tuc_enc_model enc (.aclk(aclk), .phase_input_a(pa), .phase_input_b(pb),
    .channel_reset_input(prst));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: data got %h expected %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: resp got %h expected %h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic chk_pin(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: pin got %h expected %h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  function automatic logic [7:0] cnt_addr(input int c);
    return 8'(`TUC_OFF_CNT1 + 4 * c);
  endfunction : cnt_addr

  // counts per quadrature cycle: 1, 1, 2, 2, 4 for modes 1..5
  function automatic logic [15:0] f_delta(input int mode, input bit up, input int n);
    int per;
    per = (mode == 5) ? 4 : ((mode >= 3) ? 2 : 1);
    return up ? 16'(per * n) : 16'(-(per * n));
  endfunction : f_delta

  function automatic logic [31:0] f_stat(input logic [31:0] s, input int c);
    return (s >> (2 * c)) & 32'h3;
  endfunction : f_stat

  task automatic chk_flags(input int c, input logic e);
    repeat (3) @(posedge aclk);
    chk_pin(led[c], e);
    chk_pin(foe[c], e);
    chk_pin(fo[c], e);
  endtask : chk_flags

  initial begin
    logic [31:0] d;
    logic [15:0] exp [3];
    int md [3];
    int n;
    int k;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(56));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      axi_rd(8'(4 * i), d, rsp);
      chk_data(d, 32'h0);
    end
    axi_rd(8'h20, d, rsp);
    chk_resp(rsp, `TUC_RESP_SLVERR);
    axi_wr(8'h0c, 32'hffff_ffff, 4'hf, rsp);
    chk_resp(rsp, `TUC_RESP_SLVERR);
    axi_wr(`TUC_OFF_STAT, 32'hffff_ffff, 4'hf, rsp);
    chk_resp(rsp, `TUC_RESP_OKAY);
    // quadrature modes, each channel in its own mode per round
    for (int m = 0; m < 5; m++) begin
      for (int c = 0; c < 3; c++) begin
        md[c] = 1 + (m + c) % 5;
      end
      // procedure chosen before any preset
      d = 32'(md[0] | (md[1] << 4) | (md[2] << 8));
      axi_wr(`TUC_OFF_MODE, d, 4'hf, rsp);
      for (int c = 0; c < 3; c++) begin
        exp[c] = 16'($urandom);
        axi_wr(cnt_addr(c), {16'h0, exp[c]}, 4'hf, rsp);
      end
      for (int c = 0; c < 3; c++) begin
        n = 1 + $urandom_range(2);
        k = $urandom_range(2);
        enc.quad(c, 1'b1, n);
        enc.quad(c, 1'b0, k);
        exp[c] = exp[c] + f_delta(md[c], 1'b1, n) + f_delta(md[c], 1'b0, k);
      end
      for (int c = 0; c < 3; c++) begin
        axi_rd(cnt_addr(c), d, rsp);
        chk_data(d, {16'h0, exp[c]});
      end
    end
    // mode 0 wrap, carry and borrow flags, flag pins
    axi_wr(`TUC_OFF_MODE, 32'h0, 4'hf, rsp);
    for (int c = 0; c < 3; c++) begin
      n = 1 + $urandom_range(2);
      axi_wr(cnt_addr(c), 32'h10000 - 32'(n), 4'hf, rsp);
      repeat (n) enc.pulse(c, 1'b1);
      axi_rd(cnt_addr(c), d, rsp);
      chk_data(d, 32'h0);
      axi_rd(`TUC_OFF_STAT, d, rsp);
      chk_data(f_stat(d, c), 32'h1);
      chk_flags(c, 1'b1);
      enc.pulse(c, 1'b0);
      axi_rd(cnt_addr(c), d, rsp);
      chk_data(d, 32'h0000_ffff);
      axi_rd(`TUC_OFF_STAT, d, rsp);
      chk_data(f_stat(d, c), 32'h2);
      chk_flags(c, 1'b0);
      axi_wr(`TUC_OFF_CTRL, 32'h1 << (`TUC_CTRL_SEL_LSB + c), 4'hf, rsp);
      chk_flags(c, 1'b1);
      axi_wr(cnt_addr(c), 32'h0, 4'hf, rsp);
      axi_rd(`TUC_OFF_STAT, d, rsp);
      chk_data(f_stat(d, c), 32'h0);
      chk_flags(c, 1'b0);
      axi_wr(`TUC_OFF_CTRL, 32'h0, 4'hf, rsp);
    end
    // cascade, counter 2 pins left still and in mode 0
    n = $urandom_range(16'hfffe);
    axi_wr(`TUC_OFF_CTRL, 32'h1, 4'hf, rsp);
    axi_wr(`TUC_OFF_CNT1, 32'h0000_ffff, 4'hf, rsp);
    axi_wr(`TUC_OFF_CNT2, 32'(n), 4'hf, rsp);
    enc.pulse(0, 1'b1);
    axi_rd(`TUC_OFF_CASC, d, rsp);
    chk_data(d, {16'(n + 1), 16'h0});
    enc.pulse(0, 1'b0);
    axi_rd(`TUC_OFF_CASC, d, rsp);
    chk_data(d, {16'(n), 16'hffff});
    axi_wr(`TUC_OFF_CTRL, 32'h0, 4'hf, rsp);
    // byte strobe, then per-channel reset pin
    axi_wr(`TUC_OFF_CNT3, 32'h0000_abcd, 4'hf, rsp);
    axi_wr(`TUC_OFF_CNT3, 32'h0000_0012, 4'h1, rsp);
    axi_rd(`TUC_OFF_CNT3, d, rsp);
    chk_data(d, 32'h0000_ab12);
    enc.rst(2);
    axi_rd(`TUC_OFF_CNT3, d, rsp);
    chk_data(d, 32'h0);
    // frequency mode on channel 2, pulse width mode on channel 3
    axi_wr(`TUC_OFF_MODE, 32'(tuc_pkg::TUC_MODE_FREQ) << 4, 4'hf, rsp);
    n = 1 + $urandom_range(6);
    enc.step(1, 1'b0, 1'b1);
    enc.step(1, 1'b0, 1'b0);
    repeat (n) enc.pulse(1, 1'b0);
    enc.step(1, 1'b0, 1'b1);
    axi_rd(`TUC_OFF_CNT2, d, rsp);
    chk_data(d, 32'(n));
    axi_wr(`TUC_OFF_MODE, 32'(tuc_pkg::TUC_MODE_PWIDTH) << 8, 4'hf, rsp);
    k = 2 + $urandom_range(3);
    enc.step(2, 1'b1, 1'b0);
    enc.step(2, 1'b0, 1'b0);
    repeat (25 * k - 4) @(posedge aclk);
    enc.step(2, 1'b1, 1'b0);
    axi_rd(`TUC_OFF_CNT3, d, rsp);
    chk_data({31'h0, (d >= 32'(k - 1)) && (d <= 32'(k + 1))}, 32'h1);
    complete_run();
  end
endmodule : tb
`default_nettype wire

//--- tuc_chan_in.sv
// Purpose: input stage of one counter channel, turns pins into count events
// Assumes: pins are asynchronous, ref_tick is a one-cycle pulse at 10 MHz
// Notes: two-flop synchronisers, edge detect on the second stage only
`timescale 1ns/10ps
`default_nettype none
module tuc_chan_in (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins
  input wire logic phase_input_a,
  input wire logic phase_input_b,
  input wire logic channel_reset_input,
  // control
  input wire tuc_pkg::tuc_mode_t mode,
  input wire logic ref_tick,
  // events
  output tuc_pkg::tuc_evt_t evt,
  output logic rst_lvl
);

  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [1:0] s3_ff;
  logic a, b, a_rise, a_fall, b_rise, b_fall;
  logic qa_up, qa_dn, qb_up, qb_dn, qar_up, qar_dn, qbr_up, qbr_dn;

  // synchronise {reset, b, a}
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
      s3_ff <= 2'h0;
    end else begin
      s1_ff <= {channel_reset_input, phase_input_b, phase_input_a};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff[1:0];
    end
  end

  assign a = s2_ff[0];
  assign b = s2_ff[1];
  assign rst_lvl = s2_ff[2];
  assign a_rise = a & ~s3_ff[0];
  assign a_fall = ~a & s3_ff[0];
  assign b_rise = b & ~s3_ff[1];
  assign b_fall = ~b & s3_ff[1];

  // a leading b counts up
  assign qar_up = a_rise & ~b;
  assign qar_dn = a_rise & b;
  assign qbr_up = b_rise & a;
  assign qbr_dn = b_rise & ~a;
  assign qa_up = qar_up | (a_fall & b);
  assign qa_dn = qar_dn | (a_fall & ~b);
  assign qb_up = qbr_up | (b_fall & ~a);
  assign qb_dn = qbr_dn | (b_fall & a);

  always_comb begin
    evt = '0;
    case (mode)
      tuc_pkg::TUC_MODE_UPDN: begin
        evt.up = b_rise;
        evt.dn = a_rise;
      end
      tuc_pkg::TUC_MODE_QA_RISE: begin
        evt.up = qar_up;
        evt.dn = qar_dn;
      end
      tuc_pkg::TUC_MODE_QB_RISE: begin
        evt.up = qbr_up;
        evt.dn = qbr_dn;
      end
      tuc_pkg::TUC_MODE_QA_BOTH: begin
        evt.up = qa_up;
        evt.dn = qa_dn;
      end
      tuc_pkg::TUC_MODE_QB_BOTH: begin
        evt.up = qb_up;
        evt.dn = qb_dn;
      end
      tuc_pkg::TUC_MODE_Q_ALL: begin
        evt.up = qa_up | qb_up;
        evt.dn = qa_dn | qb_dn;
      end
      tuc_pkg::TUC_MODE_PWIDTH: begin
        evt.up = ~a & ~a_fall & ref_tick & ~b;
        evt.dn = ~a & ~a_fall & ref_tick & b;
        evt.clr = a_fall;
        evt.cap = a_rise;
      end
      tuc_pkg::TUC_MODE_FREQ: begin
        evt.up = a_rise & ~b & ~b_fall;
        evt.clr = b_fall | b_rise;
        evt.cap = b_rise;
      end
      default: begin
        evt = '0;
      end
    endcase
  end

endmodule : tuc_chan_in
`default_nettype wire

//--- tuc_enc_model.sv
// Purpose: encoder and pulse source model driving the count and reset pins
// Assumes: level pins, sampled by the counter through two-flop synchronisers
// Notes: every level is held for HOLD clock edges so each edge is seen once
`timescale 1ns/10ps
`default_nettype none
module tuc_enc_model (
  // clock
  input wire logic aclk,
  // pins towards the counter
  output logic [2:0] phase_input_a,
  output logic [2:0] phase_input_b,
  output logic [2:0] channel_reset_input
);
  localparam int HOLD = 4;

  initial begin
    phase_input_a = 3'h0;
    phase_input_b = 3'h0;
    channel_reset_input = 3'h0;
  end

  // set both phase levels of one channel, other channels stay still
  task step(input int ch, input logic a, input logic b);
    @(posedge aclk);
    phase_input_a[ch] <= a;
    phase_input_b[ch] <= b;
    repeat (HOLD) @(posedge aclk);
  endtask : step

  // full quadrature cycles, a leading b when up
  task quad(input int ch, input bit up, input int n);
    for (int i = 0; i < n; i++) begin
      step(ch, up, !up);
      step(ch, 1'b1, 1'b1);
      step(ch, !up, up);
      step(ch, 1'b0, 1'b0);
    end
  endtask : quad

  // one pulse on b (sel high) or a, the other pin kept
  task pulse(input int ch, input bit sel);
    if (sel) begin
      step(ch, phase_input_a[ch], 1'b1);
      step(ch, phase_input_a[ch], 1'b0);
    end else begin
      step(ch, 1'b1, phase_input_b[ch]);
      step(ch, 1'b0, phase_input_b[ch]);
    end
  endtask : pulse

  // one active-high reset pulse
  task rst(input int ch);
    @(posedge aclk);
    channel_reset_input[ch] <= 1'b1;
    repeat (HOLD) @(posedge aclk);
    channel_reset_input[ch] <= 1'b0;
    repeat (HOLD) @(posedge aclk);
  endtask : rst
endmodule : tuc_enc_model
`default_nettype wire

//--- tuc_map.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: included by the counter top and its testbench
// Notes: byte addresses on the register bus
`ifndef TUC_MAP_SVH
`define TUC_MAP_SVH

`define TUC_OFF_CTRL 8'h00
`define TUC_OFF_MODE 8'h04
`define TUC_OFF_STAT 8'h08
`define TUC_OFF_CNT1 8'h10
`define TUC_OFF_CNT2 8'h14
`define TUC_OFF_CNT3 8'h18
`define TUC_OFF_CASC 8'h1c

`define TUC_CTRL_CASC_BIT 0
`define TUC_CTRL_SEL_LSB 1
`define TUC_MODE_STRIDE 4
`define TUC_STAT_STRIDE 2

`define TUC_CTRL_RST 32'h0000_0000
`define TUC_MODE_RST 32'h0000_0000
`define TUC_CNT_RST 16'h0000

`define TUC_CLK_HZ 250000000
`define TUC_REF_HZ 10000000
`define TUC_REF_DIV (`TUC_CLK_HZ / `TUC_REF_HZ)

`define TUC_RESP_OKAY 2'b00
`define TUC_RESP_SLVERR 2'b10

`endif

//--- tuc_pkg.sv
// Purpose: shared types of the triple up/down counter
// Assumes: nothing beyond the map header
// Notes: modes are the eight per-counter operating modes
`default_nettype none
package tuc_pkg;

  typedef enum logic [2:0] {
    TUC_MODE_UPDN = 3'h0,
    TUC_MODE_QA_RISE = 3'h1,
    TUC_MODE_QB_RISE = 3'h2,
    TUC_MODE_QA_BOTH = 3'h3,
    TUC_MODE_QB_BOTH = 3'h4,
    TUC_MODE_Q_ALL = 3'h5,
    TUC_MODE_PWIDTH = 3'h6,
    TUC_MODE_FREQ = 3'h7
  } tuc_mode_t;

  typedef struct packed {
    logic up;
    logic dn;
    logic clr;
    logic cap;
  } tuc_evt_t;

endpackage : tuc_pkg
`default_nettype wire

//--- tuc_top.sv
// Purpose: three 16-bit up/down counters with flags, behind AXI4-Lite
// Assumes: aclk 250 MHz, pins asynchronous to aclk
// Notes: count registers at CNT1..CNT3, cascade value at CASC
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "tuc_map.svh"
module tuc_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // count pins
  input wire logic [2:0] phase_input_a,
  input wire logic [2:0] phase_input_b,
  input wire logic [2:0] channel_reset_input,
  // flag pins
  output logic [2:0] flag_output_o,
  output logic [2:0] flag_output_oe,
  output logic [2:0] front_led
);

  localparam logic [4:0] REF_LAST = 5'(`TUC_REF_DIV - 1);

  // merge write data into an old word by byte strobes
  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (st[k]) begin
        r[8*k +: 8] = wd[8*k +: 8];
      end
    end
    return r;
  endfunction : merge32

  // address to counter index, 3 when not a counter
  function automatic logic [1:0] cnt_idx(input logic [7:0] ad);
    logic [1:0] r;
    r = 2'h3;
    if (ad == `TUC_OFF_CNT1) begin
      r = 2'h0;
    end else if (ad == `TUC_OFF_CNT2) begin
      r = 2'h1;
    end else if (ad == `TUC_OFF_CNT3) begin
      r = 2'h2;
    end
    return r;
  endfunction : cnt_idx

  function automatic logic addr_ok(input logic [7:0] ad);
    return (ad == `TUC_OFF_CTRL) || (ad == `TUC_OFF_MODE) || (ad == `TUC_OFF_STAT) ||
           (cnt_idx(ad) != 2'h3) || (ad == `TUC_OFF_CASC);
  endfunction : addr_ok

  logic [31:0] ctrl_ff;
  logic [31:0] mode_ff;
  logic [15:0] cnt_ff [3];
  logic [15:0] hold_ff [3];
  logic [2:0] carry_ff, borrow_ff;
  logic [2:0] flag_sel_q_ff;
  logic [4:0] ref_cnt_ff;
  logic ref_tick;
  logic casc;
  logic [2:0] flag_sel;
  tuc_pkg::tuc_evt_t evt [3];
  logic [2:0] rst_lvl;
  logic [2:0] preset, up_ok, dn_ok, carry_evt, borrow_evt;
  logic [15:0] pre_val;

  // axi state
  logic aw_got_ff, w_got_ff;
  logic [7:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_go;
  logic [31:0] nxt_rdata;
  logic [1:0] wr_idx;

  assign casc = ctrl_ff[`TUC_CTRL_CASC_BIT];
  assign flag_sel = ctrl_ff[`TUC_CTRL_SEL_LSB +: 3];

  // 10 MHz reference from aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_cnt_ff <= 5'h0;
    end else if (ref_cnt_ff == REF_LAST) begin
      ref_cnt_ff <= 5'h0;
    end else begin
      ref_cnt_ff <= ref_cnt_ff + 5'h1;
    end
  end
  assign ref_tick = (ref_cnt_ff == REF_LAST);

  // per-channel input stage, mode chosen per counter
  for (genvar g = 0; g < 3; g++) begin : g_ch
    tuc_chan_in u_in (
      .aclk(aclk),
      .aresetn(aresetn),
      .phase_input_a(phase_input_a[g]),
      .phase_input_b(phase_input_b[g]),
      .channel_reset_input(channel_reset_input[g]),
      .mode(tuc_pkg::tuc_mode_t'(mode_ff[`TUC_MODE_STRIDE*g +: 3])),
      .ref_tick(ref_tick),
      .evt(evt[g]),
      .rst_lvl(rst_lvl[g])
    );
  end

  // axi write channel capture, either order
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
  assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign wr_idx = cnt_idx(waddr_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      waddr_ff <= 8'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      waddr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_ff <= 1'b0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wr_go) begin
      w_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TUC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_ok(waddr_ff) ? `TUC_RESP_OKAY : `TUC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control and mode registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `TUC_CTRL_RST;
      mode_ff <= `TUC_MODE_RST;
    end else if (wr_go && waddr_ff == `TUC_OFF_CTRL) begin
      ctrl_ff <= merge32(ctrl_ff, wdata_ff, wstrb_ff) & 32'h0000_000f;
    end else if (wr_go && waddr_ff == `TUC_OFF_MODE) begin
      mode_ff <= merge32(mode_ff, wdata_ff, wstrb_ff) & 32'h0000_0777;
    end
  end

  // preset decode, one 16-bit value per counter
  always_comb begin
    preset = 3'h0;
    pre_val = `TUC_CNT_RST;
    if (wr_go && wr_idx != 2'h3) begin
      preset[wr_idx] = 1'b1;
      pre_val = 16'(merge32({16'h0, cnt_ff[wr_idx]}, wdata_ff, wstrb_ff));
    end
  end

  // qualified count events, counter 2 fed by counter 1 when cascaded
  always_comb begin
    logic ovr, s_up, s_dn;
    ovr = 1'b0;
    s_up = 1'b0;
    s_dn = 1'b0;
    up_ok = 3'h0;
    dn_ok = 3'h0;
    carry_evt = 3'h0;
    borrow_evt = 3'h0;
    for (int i = 0; i < 3; i++) begin
      ovr = rst_lvl[i] | preset[i] | evt[i].clr;
      s_up = evt[i].up;
      s_dn = evt[i].dn;
      if (i == 1 && casc) begin
        s_up = carry_evt[0];
        s_dn = borrow_evt[0];
      end
      up_ok[i] = !ovr && s_up;
      dn_ok[i] = !ovr && !s_up && s_dn;
      carry_evt[i] = up_ok[i] && (cnt_ff[i] == 16'hffff);
      borrow_evt[i] = dn_ok[i] && (cnt_ff[i] == 16'h0000);
    end
  end

  // counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) begin
        cnt_ff[i] <= `TUC_CNT_RST;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (rst_lvl[i]) begin
          cnt_ff[i] <= `TUC_CNT_RST;
        end else if (preset[i]) begin
          cnt_ff[i] <= pre_val;
        end else if (evt[i].clr) begin
          cnt_ff[i] <= `TUC_CNT_RST;
        end else if (up_ok[i]) begin
          cnt_ff[i] <= cnt_ff[i] + 16'h1;
        end else if (dn_ok[i]) begin
          cnt_ff[i] <= cnt_ff[i] - 16'h1;
        end
      end
    end
  end

  // measured value register for modes 6 and 7
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) begin
        hold_ff[i] <= `TUC_CNT_RST;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (evt[i].cap) begin
          hold_ff[i] <= cnt_ff[i];
        end
      end
    end
  end

  // sticky flags, a new event wins over any clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carry_ff <= 3'h0;
      borrow_ff <= 3'h0;
    end else begin
      carry_ff <= (carry_ff & ~(borrow_evt | preset)) | carry_evt;
      borrow_ff <= (borrow_ff & ~(carry_evt | preset)) | borrow_evt;
    end
  end

  // flag routing to led and switched output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_sel_q_ff <= 3'h0;
    end else begin
      flag_sel_q_ff <= (flag_sel & borrow_ff) | (~flag_sel & carry_ff);
    end
  end
  assign front_led = flag_sel_q_ff;
  assign flag_output_oe = flag_sel_q_ff;
  assign flag_output_o = flag_sel_q_ff;

  // read data
  always_comb begin
    logic [1:0] ri;
    logic [2:0] md;
    ri = cnt_idx(s_axi_araddr);
    md = 3'h0;
    nxt_rdata = 32'h0;
    if (ri != 2'h3) begin
      md = mode_ff[`TUC_MODE_STRIDE*ri +: 3];
      nxt_rdata = {16'h0, (md == tuc_pkg::TUC_MODE_PWIDTH || md == tuc_pkg::TUC_MODE_FREQ) ?
                   hold_ff[ri] : cnt_ff[ri]};
    end else if (s_axi_araddr == `TUC_OFF_CTRL) begin
      nxt_rdata = ctrl_ff;
    end else if (s_axi_araddr == `TUC_OFF_MODE) begin
      nxt_rdata = mode_ff;
    end else if (s_axi_araddr == `TUC_OFF_STAT) begin
      for (int i = 0; i < 3; i++) begin
        nxt_rdata[`TUC_STAT_STRIDE*i +: 2] = {borrow_ff[i], carry_ff[i]};
      end
    end else if (s_axi_araddr == `TUC_OFF_CASC) begin
      nxt_rdata = {cnt_ff[1], cnt_ff[0]};
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `TUC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= nxt_rdata;
      s_axi_rresp <= addr_ok(s_axi_araddr) ? `TUC_RESP_OKAY : `TUC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_carry_latch;
    carry_evt[0] |=> carry_ff[0] && !borrow_ff[0];
  endproperty
  a_carry_latch: assert property (p_carry_latch) else $error("carry not latched");

  property p_borrow_clears_carry;
    carry_ff[1] && borrow_evt[1] |=> !carry_ff[1] && borrow_ff[1];
  endproperty
  a_borrow_clears_carry: assert property (p_borrow_clears_carry)
    else $error("borrow did not clear carry");

  property p_preset_clears;
    preset[2] |=> !carry_ff[2] && !borrow_ff[2] &&
      (cnt_ff[2] == $past(pre_val) || $past(rst_lvl[2]));
  endproperty
  a_preset_clears: assert property (p_preset_clears) else $error("preset not applied");

  property p_chan_reset;
    rst_lvl[2] |=> cnt_ff[2] == 16'h0000;
  endproperty
  a_chan_reset: assert property (p_chan_reset) else $error("channel reset ignored");

  property p_step_up;
    up_ok[0] |=> cnt_ff[0] == $past(cnt_ff[0]) + 16'h1;
  endproperty
  a_step_up: assert property (p_step_up) else $error("count step wrong");

  property p_wrap_down;
    borrow_evt[2] |=> cnt_ff[2] == 16'hffff && borrow_ff[2];
  endproperty
  a_wrap_down: assert property (p_wrap_down) else $error("down wrap wrong");

  property p_cascade;
    casc && carry_evt[0] && !rst_lvl[1] && !preset[1] |=> cnt_ff[1] == $past(cnt_ff[1]) + 16'h1;
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade carry lost");

  property p_flag_route;
    ##1 flag_output_oe[0] == ($past(flag_sel[0]) ? $past(borrow_ff[0]) : $past(carry_ff[0]));
  endproperty
  a_flag_route: assert property (p_flag_route) else $error("flag routing wrong");

  property p_flag_drive;
    ##1 flag_output_o[1] == flag_output_oe[1] &&
      flag_output_oe[1] == $past(flag_sel[1] ? borrow_ff[1] : carry_ff[1]);
  endproperty
  a_flag_drive: assert property (p_flag_drive) else $error("flag not driven high");

endmodule : tuc_top
`default_nettype wire
